// file: core/mbs_cond.sv
// Condition code evaluator for conditional jumps and conditional calls.
// Assumes flags arrive as a stable level from the status word.
`timescale 1ns/10ps
module mbs_cond (
    input  wire logic [3:0] cond,
    input  wire logic [3:0] flags,
    output logic            ok
);
    always_comb begin
        case (cond)
            mbs_pkg::CC_UC: ok = 1'b1;
            mbs_pkg::CC_Z:  ok = flags[mbs_pkg::FLAG_Z];
            mbs_pkg::CC_NZ: ok = !flags[mbs_pkg::FLAG_Z];
            mbs_pkg::CC_C:  ok = flags[mbs_pkg::FLAG_C];
            mbs_pkg::CC_NC: ok = !flags[mbs_pkg::FLAG_C];
            mbs_pkg::CC_N:  ok = flags[mbs_pkg::FLAG_N];
            mbs_pkg::CC_NN: ok = !flags[mbs_pkg::FLAG_N];
            mbs_pkg::CC_V:  ok = flags[mbs_pkg::FLAG_V];
            mbs_pkg::CC_NV: ok = !flags[mbs_pkg::FLAG_V];
            default:        ok = 1'b0;
        endcase
    end
endmodule

// file: core/mbs_exec.sv
// Execution unit for moves, shifts, jumps, segment_call, traps, stack and return operations.
// Assumes one decoded instruction per start pulse, accepted only while idle.
// Operation
// - Two-byte rotate left and rotate right of a work register
// - Two-byte arithmetic right shift filling vacated bits with the sign
// - Word and byte moves, two or four bytes long by operand form
// - Byte into word with sign extension or zero extension
// - Four-byte conditional jump, absolute, indirect or relative, else skipped
// - Four-byte absolute jump that also loads the code segment
// - Relative branch when bit is one; clearing variant resets it when taken
// - Relative branch when bit is zero; setting variant sets it when taken
// - Four-byte conditional call; a taken call saves the return offset
// - Four-byte far call saving return segment and return offset
// - Push a work register, then absolute call
// - Two-byte trap entering a service routine chosen by immediate number
// - Two-byte push of a register, or pop into it
// - Context switch pushes a register then loads it with an operand
// - Near return; alternate form also pops a work register
// - Far return restores code segment and offset
// - Near return restores offset only, code segment unchanged
`timescale 1ns/10ps
module mbs_exec (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              start,
    input  wire mbs_pkg::mbs_op_t  op,
    input  wire mbs_pkg::mbs_tgt_t tgt_mode,
    input  wire logic              use_imm,
    input  wire logic [3:0]        reg_a,
    input  wire logic [3:0]        reg_b,
    input  wire logic [15:0]       imm,
    input  wire logic [15:0]       target,
    input  wire logic [7:0]        seg_in,
    input  wire logic [3:0]        bit_pos,
    input  wire logic [3:0]        cond,
    input  wire logic [3:0]        flags,
    input  wire logic [3:0]        obs_idx,
    output logic                   busy,
    output logic                   int_block,
    output logic                   done,
    output logic                   taken,
    output logic [2:0]             instr_len,
    output logic [15:0]            ip,
    output logic [7:0]             code_seg,
    output logic [15:0]            sp,
    output logic [15:0]            obs_data
);
    mbs_pkg::mbs_state_t state;
    mbs_pkg::mbs_state_t next_state;
    mbs_pkg::mbs_op_t    op_q;
    logic [15:0]         general_work_register [16];
    logic [15:0]         stk [16];
    logic [3:0]          reg_a_q;
    logic [7:0]          seg_q;
    logic [15:0]         ret_ip_q;
    logic [15:0]         jump_q;
    logic [15:0]         next_ip;
    logic [7:0]          next_seg;
    logic                next_taken;
    logic                fin;
    logic                push_en;
    logic [15:0]         push_data;
    logic                pop_en;
    logic                gpr_we;
    logic [3:0]          gpr_widx;
    logic [15:0]         gpr_wdata;
    logic [15:0]         alu_out;
    logic                cond_ok;

    wire        go       = start && state == mbs_pkg::st_idle;
    wire [2:0]  len      = mbs_pkg::mbs_len(op, use_imm);
    wire [15:0] a_val    = general_work_register[reg_a];
    wire [15:0] src      = use_imm ? imm : general_work_register[reg_b];
    wire [15:0] ret_ip   = ip + {13'h0000, len};
    wire [15:0] rel_ip   = ret_ip + target;
    wire [15:0] bit_mask = 16'h0001 << bit_pos;
    wire        bit_val  = a_val[bit_pos];
    wire [15:0] sp_dec   = sp - mbs_pkg::SP_STEP;
    wire [15:0] sp_inc   = sp + mbs_pkg::SP_STEP;
    wire [15:0] pop_data = stk[sp[4:1]];
    wire [15:0] trap_vec = {7'h00, imm[6:0], 2'h0};
    wire [15:0] tgt_eff  = (tgt_mode == mbs_pkg::tgt_ind) ? general_work_register[reg_b] :
                           (tgt_mode == mbs_pkg::tgt_rel) ? rel_ip : target;

    assign busy      = state != mbs_pkg::st_idle;
    // Held off over the whole instruction so a bit test and its update stay indivisible
    assign int_block = busy || start;

    mbs_shift_ext u_alu (
        .op (op),
        .a  (a_val),
        .b  (src),
        .y  (alu_out)
    );

    mbs_cond u_cond (
        .cond  (cond),
        .flags (flags),
        .ok    (cond_ok)
    );

    always_comb begin
        next_state = state;
        next_ip    = ip;
        next_seg   = code_seg;
        next_taken = 1'b0;
        fin        = 1'b0;
        push_en    = 1'b0;
        push_data  = a_val;
        pop_en     = 1'b0;
        gpr_we     = 1'b0;
        gpr_widx   = reg_a;
        gpr_wdata  = alu_out;
        case (state)
            mbs_pkg::st_idle: begin
                if (start) begin
                    next_ip = ret_ip;
                    fin     = 1'b1;
                    case (op)
                        mbs_pkg::op_rot_left, mbs_pkg::op_rot_right: begin
                            gpr_we = 1'b1;
                        end
                        mbs_pkg::op_sign_shift: begin
                            gpr_we = 1'b1;
                        end
                        mbs_pkg::op_move_word, mbs_pkg::op_move_byte: begin
                            gpr_we = 1'b1;
                        end
                        mbs_pkg::op_extend_sign, mbs_pkg::op_extend_zero: begin
                            gpr_we = 1'b1;
                        end
                        mbs_pkg::op_cond_jump: begin
                            if (cond_ok) begin
                                next_ip    = tgt_eff;
                                next_taken = 1'b1;
                            end
                        end
                        mbs_pkg::op_seg_jump: begin
                            next_ip    = target;
                            next_seg   = seg_in;
                            next_taken = 1'b1;
                        end
                        mbs_pkg::op_bit_one_jump, mbs_pkg::op_bit_one_clear: begin
                            if (bit_val) begin
                                next_ip    = rel_ip;
                                next_taken = 1'b1;
                                gpr_we     = op == mbs_pkg::op_bit_one_clear;
                                gpr_wdata  = a_val & ~bit_mask;
                            end
                        end
                        mbs_pkg::op_bit_zero_jump, mbs_pkg::op_bit_zero_set: begin
                            if (!bit_val) begin
                                next_ip    = rel_ip;
                                next_taken = 1'b1;
                                gpr_we     = op == mbs_pkg::op_bit_zero_set;
                                gpr_wdata  = a_val | bit_mask;
                            end
                        end
                        mbs_pkg::op_cond_call: begin
                            if (cond_ok) begin
                                push_en    = 1'b1;
                                push_data  = ret_ip;
                                next_ip    = tgt_eff;
                                next_taken = 1'b1;
                            end
                        end
                        mbs_pkg::op_seg_call, mbs_pkg::op_trap: begin
                            // Segment goes first so the far return pops offset then segment
                            push_en    = 1'b1;
                            push_data  = {8'h00, code_seg};
                            next_ip    = ip;
                            fin        = 1'b0;
                            next_state = mbs_pkg::st_push2;
                        end
                        mbs_pkg::op_save_call: begin
                            push_en    = 1'b1;
                            next_ip    = ip;
                            fin        = 1'b0;
                            next_state = mbs_pkg::st_push2;
                        end
                        mbs_pkg::op_push: begin
                            push_en = 1'b1;
                        end
                        mbs_pkg::op_pop: begin
                            pop_en    = 1'b1;
                            gpr_we    = 1'b1;
                            gpr_wdata = pop_data;
                        end
                        mbs_pkg::op_ctx_switch: begin
                            push_en   = 1'b1;
                            gpr_we    = 1'b1;
                            gpr_wdata = src;
                        end
                        mbs_pkg::op_near_ret: begin
                            pop_en  = 1'b1;
                            next_ip = pop_data;
                        end
                        mbs_pkg::op_near_ret_pop, mbs_pkg::op_far_ret: begin
                            pop_en     = 1'b1;
                            next_ip    = pop_data;
                            fin        = 1'b0;
                            next_state = mbs_pkg::st_pop2;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            mbs_pkg::st_push2: begin
                push_en    = 1'b1;
                push_data  = ret_ip_q;
                next_ip    = jump_q;
                next_taken = 1'b1;
                fin        = 1'b1;
                next_state = mbs_pkg::st_idle;
                if (op_q == mbs_pkg::op_seg_call) begin
                    next_seg = seg_q;
                end else if (op_q == mbs_pkg::op_trap) begin
                    next_seg = mbs_pkg::TRAP_SEG;
                end
            end
            mbs_pkg::st_pop2: begin
                pop_en     = 1'b1;
                fin        = 1'b1;
                next_state = mbs_pkg::st_idle;
                gpr_widx   = reg_a_q;
                gpr_wdata  = pop_data;
                gpr_we     = op_q == mbs_pkg::op_near_ret_pop;
                if (op_q == mbs_pkg::op_far_ret) begin
                    next_seg = pop_data[7:0];
                end
            end
            default: begin
                next_state = mbs_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state    <= mbs_pkg::st_idle;
            ip       <= mbs_pkg::IP_RESET;
            code_seg <= mbs_pkg::SEG_RESET;
            sp       <= mbs_pkg::SP_RESET;
            done     <= 1'b0;
            taken    <= 1'b0;
        end else begin
            state    <= next_state;
            ip       <= next_ip;
            code_seg <= next_seg;
            // Push and pop never share a cycle
            sp       <= push_en ? sp_dec : (pop_en ? sp_inc : sp);
            done     <= fin;
            taken    <= next_taken;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_q      <= mbs_pkg::op_nop;
            reg_a_q   <= 4'h0;
            seg_q     <= 8'h00;
            ret_ip_q  <= 16'h0000;
            jump_q    <= 16'h0000;
            instr_len <= 3'h0;
            obs_data  <= 16'h0000;
        end else begin
            obs_data <= general_work_register[obs_idx];
            if (go) begin
                op_q      <= op;
                reg_a_q   <= reg_a;
                seg_q     <= seg_in;
                ret_ip_q  <= ret_ip;
                jump_q    <= (op == mbs_pkg::op_trap) ? trap_vec : target;
                instr_len <= len;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                general_work_register[i] <= 16'h0000;
            end
        end else if (gpr_we) begin
            general_work_register[gpr_widx] <= gpr_wdata;
        end
    end

    // Stack words sit at sp[4:1]; no reset, contents are data only
    always_ff @(posedge clk) begin
        if (push_en) begin
            stk[sp_dec[4:1]] <= push_data;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_far_call;
        go && op == mbs_pkg::op_seg_call;
    endsequence

    sequence s_far_ret;
        go && op == mbs_pkg::op_far_ret;
    endsequence

    a_rot_left_wraps:
        assert property (go && op == mbs_pkg::op_rot_left && src[3:0] == 4'h4
            |=> general_work_register[$past(reg_a)] == {$past(a_val[11:0]), $past(a_val[15:12])})
        else $error("rotate left by four lost the wrapped bits");

    a_shift_sign_fill:
        assert property (go && op == mbs_pkg::op_sign_shift && a_val[15] && src[3:0] == 4'h4
            |=> general_work_register[$past(reg_a)] == {4'hf, $past(a_val[15:4])})
        else $error("arithmetic shift did not copy the sign bit");

    a_extend_zero_high:
        assert property (go && op == mbs_pkg::op_extend_zero
            |=> general_work_register[$past(reg_a)][15:8] == 8'h00)
        else $error("zero extension left upper byte nonzero");

    a_jump_skip_len:
        assert property (go && op == mbs_pkg::op_cond_jump && !cond_ok
            |=> ip == $past(ip) + {13'h0000, mbs_pkg::LEN_LONG} && !taken)
        else $error("skipped jump did not advance by four bytes");

    a_seg_jump_load:
        assert property (go && op == mbs_pkg::op_seg_jump
            |=> code_seg == $past(seg_in) && ip == $past(target))
        else $error("segment jump did not load segment and offset");

    a_bit_clear_taken:
        assert property (go && op == mbs_pkg::op_bit_one_clear && bit_val
            |=> general_work_register[$past(reg_a)][$past(bit_pos)] == 1'b0 && ip == $past(rel_ip))
        else $error("branch on one did not clear the bit");

    a_bit_set_taken:
        assert property (go && op == mbs_pkg::op_bit_zero_set && !bit_val
            |=> general_work_register[$past(reg_a)][$past(bit_pos)] == 1'b1 && ip == $past(rel_ip))
        else $error("branch on zero did not set the bit");

    a_call_saves_ret:
        assert property (go && op == mbs_pkg::op_cond_call && cond_ok
            |=> stk[sp[4:1]] == $past(ret_ip) && sp == $past(sp) - mbs_pkg::SP_STEP)
        else $error("taken call did not save return offset");

    a_far_call_two:
        assert property (s_far_call |=> busy ##1 (!busy && done && code_seg == $past(seg_q)
            && sp == $past(sp, 2) - 16'h0004))
        else $error("far call did not push twice and load segment");

    a_far_ret_both:
        assert property (s_far_ret |=> busy ##1 (code_seg == $past(pop_data[7:0])
            && sp == $past(sp, 2) + 16'h0004))
        else $error("far return did not restore segment");

    a_near_ret_seg:
        assert property (go && op == mbs_pkg::op_near_ret
            |=> code_seg == $past(code_seg) && ip == $past(pop_data))
        else $error("near return changed the code segment");

    a_pop_increments:
        assert property (pop_en && !push_en |=> sp == $past(sp) + mbs_pkg::SP_STEP)
        else $error("pop did not raise the stack pointer by two");

    a_bit_op_atomic:
        assert property (go && op inside {mbs_pkg::op_bit_one_clear, mbs_pkg::op_bit_zero_set}
            |-> int_block ##1 (done && !busy && taken == (general_work_register[$past(reg_a)][$past(bit_pos)] != $past(bit_val))))
        else $error("bit test and update not indivisible");
endmodule

// file: core/mbs_pkg.sv
// Shared types and constants for the move, branch and stack execution unit.
// Assumes a 16-bit word core with sixteen work registers and a byte-addressed stack.
package mbs_pkg;
    typedef enum logic [4:0] {
        op_nop, op_rot_left, op_rot_right, op_sign_shift,
        op_move_word, op_move_byte, op_extend_sign, op_extend_zero,
        op_cond_jump, op_seg_jump,
        op_bit_one_jump, op_bit_one_clear, op_bit_zero_jump, op_bit_zero_set,
        op_cond_call, op_seg_call, op_save_call, op_trap,
        op_push, op_pop, op_ctx_switch,
        op_near_ret, op_near_ret_pop, op_far_ret
    } mbs_op_t;

    typedef enum logic [1:0] {tgt_abs, tgt_ind, tgt_rel} mbs_tgt_t;

    typedef enum logic [1:0] {st_idle, st_push2, st_pop2} mbs_state_t;

    localparam logic [15:0] IP_RESET  = 16'h0000;
    localparam logic [7:0]  SEG_RESET = 8'h00;
    localparam logic [15:0] SP_RESET  = 16'h0020;
    localparam logic [15:0] SP_STEP   = 16'h0002;
    localparam logic [7:0]  TRAP_SEG  = 8'h00;
    localparam logic [2:0]  LEN_SHORT = 3'h2;
    localparam logic [2:0]  LEN_LONG  = 3'h4;

    // Flag positions in the flags input
    localparam int FLAG_Z = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 2;
    localparam int FLAG_N = 3;

    localparam logic [3:0] CC_UC = 4'h0;
    localparam logic [3:0] CC_Z  = 4'h1;
    localparam logic [3:0] CC_NZ = 4'h2;
    localparam logic [3:0] CC_C  = 4'h3;
    localparam logic [3:0] CC_NC = 4'h4;
    localparam logic [3:0] CC_N  = 4'h5;
    localparam logic [3:0] CC_NN = 4'h6;
    localparam logic [3:0] CC_V  = 4'h7;
    localparam logic [3:0] CC_NV = 4'h8;

    function automatic logic [2:0] mbs_len(input mbs_op_t op, input logic use_imm);
        case (op)
            op_move_word, op_move_byte, op_extend_sign, op_extend_zero, op_ctx_switch:
                mbs_len = use_imm ? LEN_LONG : LEN_SHORT;
            op_cond_jump, op_seg_jump, op_bit_one_jump, op_bit_one_clear, op_bit_zero_jump,
            op_bit_zero_set, op_cond_call, op_seg_call, op_save_call:
                mbs_len = LEN_LONG;
            default:
                mbs_len = LEN_SHORT;
        endcase
    endfunction
endpackage

// file: core/mbs_shift_ext.sv
// Rotate, sign-fill shift, byte move and byte extension data path.
// Assumes operands are stable in the cycle the result is used.
`timescale 1ns/10ps
module mbs_shift_ext (
    input  wire mbs_pkg::mbs_op_t op,
    input  wire logic [15:0]      a,
    input  wire logic [15:0]      b,
    output logic      [15:0]      y
);
    wire [3:0]  amt   = b[3:0];
    wire [31:0] rot_l = {a, a} << amt;
    wire [31:0] rot_r = {a, a} >> amt;
    wire [15:0] sra   = 16'($signed(a) >>> amt);

    always_comb begin
        case (op)
            mbs_pkg::op_rot_left:    y = rot_l[31:16];
            mbs_pkg::op_rot_right:   y = rot_r[15:0];
            mbs_pkg::op_sign_shift:  y = sra;
            mbs_pkg::op_move_byte:   y = {a[15:8], b[7:0]};
            mbs_pkg::op_extend_sign: y = {{8{b[7]}}, b[7:0]};
            mbs_pkg::op_extend_zero: y = {8'h00, b[7:0]};
            default:                 y = b;
        endcase
    end
endmodule

// file: verification/mbs_exec_tb_top.sv
// Self-checking bench for the move, branch and stack execution unit.
// Assumes the unit's package is compiled first; the bench drives every port itself.
`timescale 1ns/10ps
module mbs_exec_tb_top;
    typedef struct packed {
        logic [4:0]  op;
        logic [1:0]  tm;
        logic        ui;
        logic [3:0]  ra;
        logic [3:0]  rb;
        logic [15:0] imm;
        logic [15:0] tg;
        logic [7:0]  cf;
        logic [15:0] ev;
        logic [15:0] eip;
        logic [15:0] esp;
        logic [7:0]  eseg;
        logic [1:0]  etk;
    } mbs_row_t;

    // Taken masks by condition code for flags all clear / all set; code 9 is unknown
    localparam logic [9:0] MASK_CLR = 10'h155;
    localparam logic [9:0] MASK_SET = 10'h0ab;

    logic              clk      = 1'b0;
    logic              reset    = 1'b1;
    logic              start    = 1'b0;
    mbs_pkg::mbs_op_t  op       = mbs_pkg::op_nop;
    mbs_pkg::mbs_tgt_t tgt_mode = mbs_pkg::tgt_abs;
    logic              use_imm  = 1'b0;
    logic [3:0]        reg_a    = 4'h0;
    logic [3:0]        reg_b    = 4'h0;
    logic [15:0]       imm      = 16'h0;
    logic [15:0]       target   = 16'h0;
    logic [7:0]        seg_in   = 8'h0;
    logic [3:0]        bit_pos  = 4'h0;
    logic [3:0]        cond     = 4'h0;
    logic [3:0]        flags    = 4'h0;
    logic [3:0]        obs_idx  = 4'h0;
    logic              busy;
    logic              int_block;
    logic              done;
    logic              taken;
    logic [2:0]        instr_len;
    logic [15:0]       ip;
    logic [7:0]        code_seg;
    logic [15:0]       sp;
    logic [15:0]       obs_data;
    int                miscompares  = 0;
    int                total_checks = 0;
    logic [15:0]       cur;
    logic              tk;

    // Op codes are enum positions: seg and bit number ride on imm[7:0] and imm[3:0]
    mbs_row_t rows [29] = '{
        '{5'h04,2'h0,1'h1,4'h1,4'h0,16'h8001,16'h0,8'h00,16'h8001,16'h0004,16'h20,8'h00,2'h0},
        '{5'h04,2'h0,1'h0,4'h2,4'h1,16'h0,16'h0,8'h00,16'h8001,16'h0006,16'h20,8'h00,2'h0},
        '{5'h04,2'h0,1'h1,4'h3,4'h0,16'h0004,16'h0,8'h00,16'h0004,16'h000a,16'h20,8'h00,2'h0},
        '{5'h01,2'h0,1'h0,4'h2,4'h3,16'h0,16'h0,8'h00,16'h0018,16'h000c,16'h20,8'h00,2'h0},
        '{5'h02,2'h0,1'h0,4'h2,4'h3,16'h0,16'h0,8'h00,16'h8001,16'h000e,16'h20,8'h00,2'h0},
        '{5'h03,2'h0,1'h0,4'h2,4'h3,16'h0,16'h0,8'h00,16'hf800,16'h0010,16'h20,8'h00,2'h0},
        '{5'h05,2'h0,1'h1,4'h2,4'h0,16'h00a5,16'h0,8'h00,16'hf8a5,16'h0014,16'h20,8'h00,2'h0},
        '{5'h06,2'h0,1'h1,4'h4,4'h0,16'h7f85,16'h0,8'h00,16'hff85,16'h0018,16'h20,8'h00,2'h0},
        '{5'h07,2'h0,1'h1,4'h5,4'h0,16'h7f85,16'h0,8'h00,16'h0085,16'h001c,16'h20,8'h00,2'h0},
        '{5'h08,2'h0,1'h0,4'h5,4'h0,16'h0,16'h0100,8'h11,16'h0085,16'h0100,16'h20,8'h00,2'h1},
        '{5'h08,2'h1,1'h0,4'h5,4'h3,16'h0,16'h0,8'h00,16'h0085,16'h0004,16'h20,8'h00,2'h1},
        '{5'h09,2'h0,1'h0,4'h5,4'h0,16'h0012,16'h0200,8'h00,16'h0085,16'h0200,16'h20,8'h12,2'h1},
        '{5'h0a,2'h2,1'h0,4'h2,4'h0,16'h0,16'h10,8'h00,16'hf8a5,16'h0214,16'h20,8'h12,2'h1},
        '{5'h0b,2'h2,1'h0,4'h2,4'h0,16'h0,16'h10,8'h00,16'hf8a4,16'h0228,16'h20,8'h12,2'h1},
        '{5'h0b,2'h2,1'h0,4'h2,4'h0,16'h0,16'h10,8'h00,16'hf8a4,16'h022c,16'h20,8'h12,2'h0},
        '{5'h0d,2'h2,1'h0,4'h2,4'h0,16'h1,16'h10,8'h00,16'hf8a6,16'h0240,16'h20,8'h12,2'h1},
        '{5'h0c,2'h2,1'h0,4'h2,4'h0,16'h1,16'h10,8'h00,16'hf8a6,16'h0244,16'h20,8'h12,2'h0},
        '{5'h0e,2'h0,1'h0,4'h5,4'h0,16'h0,16'h0300,8'h00,16'h0085,16'h0300,16'h1e,8'h12,2'h1},
        '{5'h15,2'h0,1'h0,4'h5,4'h0,16'h0,16'h0,8'h00,16'h0085,16'h0248,16'h20,8'h12,2'h2},
        '{5'h0f,2'h0,1'h0,4'h5,4'h0,16'h0034,16'h0400,8'h00,16'h0085,16'h0400,16'h1c,8'h34,2'h1},
        '{5'h17,2'h0,1'h0,4'h5,4'h0,16'h0,16'h0,8'h00,16'h0085,16'h024c,16'h20,8'h12,2'h2},
        '{5'h12,2'h0,1'h0,4'h2,4'h0,16'h0,16'h0,8'h00,16'hf8a6,16'h024e,16'h1e,8'h12,2'h2},
        '{5'h13,2'h0,1'h0,4'h6,4'h0,16'h0,16'h0,8'h00,16'hf8a6,16'h0250,16'h20,8'h12,2'h2},
        '{5'h14,2'h0,1'h1,4'h2,4'h0,16'h1234,16'h0,8'h00,16'h1234,16'h0254,16'h1e,8'h12,2'h2},
        '{5'h13,2'h0,1'h0,4'h7,4'h0,16'h0,16'h0,8'h00,16'hf8a6,16'h0256,16'h20,8'h12,2'h2},
        '{5'h10,2'h0,1'h0,4'h5,4'h0,16'h0,16'h0500,8'h00,16'h0085,16'h0500,16'h1c,8'h12,2'h1},
        '{5'h16,2'h0,1'h0,4'h8,4'h0,16'h0,16'h0,8'h00,16'h0085,16'h025a,16'h20,8'h12,2'h2},
        '{5'h11,2'h0,1'h0,4'h5,4'h0,16'h0005,16'h0,8'h00,16'h0085,16'h0014,16'h1c,8'h00,2'h1},
        '{5'h17,2'h0,1'h0,4'h5,4'h0,16'h0,16'h0,8'h00,16'h0085,16'h025c,16'h20,8'h12,2'h2}
    };

    always #20 clk = ~clk;

    mbs_exec u_mbs_exec (
        .clk       (clk),
        .reset     (reset),
        .start     (start),
        .op        (op),
        .tgt_mode  (tgt_mode),
        .use_imm   (use_imm),
        .reg_a     (reg_a),
        .reg_b     (reg_b),
        .imm       (imm),
        .target    (target),
        .seg_in    (seg_in),
        .bit_pos   (bit_pos),
        .cond      (cond),
        .flags     (flags),
        .obs_idx   (obs_idx),
        .busy      (busy),
        .int_block (int_block),
        .done      (done),
        .taken     (taken),
        .instr_len (instr_len),
        .ip        (ip),
        .code_seg  (code_seg),
        .sp        (sp),
        .obs_data  (obs_data)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic run_row(input mbs_row_t r);
        int n;
        @(posedge clk);
        op       <= mbs_pkg::mbs_op_t'(r.op);
        tgt_mode <= mbs_pkg::mbs_tgt_t'(r.tm);
        use_imm  <= r.ui;
        reg_a    <= r.ra;
        reg_b    <= r.rb;
        imm      <= r.imm;
        target   <= r.tg;
        seg_in   <= r.imm[7:0];
        bit_pos  <= r.imm[3:0];
        cond     <= r.cf[7:4];
        flags    <= r.cf[3:0];
        obs_idx  <= r.ra;
        start    <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        @(negedge clk);
        while (done !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0, done}, 16'h1);
        if (r.etk != 2'h2) chk({15'h0, taken}, {15'h0, r.etk[0]});
        chk(ip, r.eip);
        chk(sp, r.esp);
        chk({8'h0, code_seg}, {8'h0, r.eseg});
        @(negedge clk);
        chk(obs_data, r.ev);
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(sp, 16'h0020);
        foreach (rows[i]) run_row(rows[i]);
        $display("table test finished");
        cur = 16'h025c;
        for (int i = 0; i < 20; i++) begin
            tk = (i < 10) ? MASK_CLR[i] : MASK_SET[i - 10];
            cur = cur + 16'h4 + (tk ? 16'h10 : 16'h0);
            run_row('{5'h08, 2'h2, 1'h0, 4'h5, 4'h0, 16'h0, 16'h10, {4'(i % 10), (i < 10) ? 4'h0 : 4'hf},
                      16'h0085, cur, 16'h20, 8'h12, {1'b0, tk}});
        end
        $display("condition test finished");
        // Back to back moves, then a push offered while the far call is busy
        @(posedge clk);
        op      <= mbs_pkg::op_move_word;
        use_imm <= 1'b1;
        reg_a   <= 4'h9;
        imm     <= 16'h1111;
        start   <= 1'b1;
        @(posedge clk);
        reg_a <= 4'ha;
        imm   <= 16'h2222;
        @(negedge clk) chk({15'h0, done}, 16'h1);
        @(posedge clk);
        op       <= mbs_pkg::op_seg_call;
        tgt_mode <= mbs_pkg::tgt_abs;
        seg_in   <= 8'h56;
        target   <= 16'h0600;
        @(negedge clk) chk({15'h0, done}, 16'h1);
        @(posedge clk);
        op <= mbs_pkg::op_push;
        @(negedge clk) chk({13'h0, int_block, busy, done}, 16'h6);
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk) chk({15'h0, done}, 16'h1);
        chk(sp, 16'h001c);
        chk(ip, 16'h0600);
        chk({8'h0, code_seg}, 16'h0056);
        chk({13'h0, instr_len}, 16'h4);
        @(posedge clk);
        obs_idx <= 4'h9;
        @(posedge clk);
        obs_idx <= 4'ha;
        @(negedge clk) chk(obs_data, 16'h1111);
        @(negedge clk) chk(obs_data, 16'h2222);
        $display("back to back test finished");
        @(posedge clk);
        reset <= 1'b1;
        @(negedge clk) chk(ip, 16'h0);
        chk(sp, 16'h0020);
        chk({7'h0, code_seg, busy}, 16'h0);
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        @(negedge clk) chk(obs_data, 16'h0);
        $display("reset test finished");
        wrap_up();
    end
endmodule
